// file: ccg_bus_partner.sv
// Behavioural memory and slow I/O responder on the far side of the bus
`timescale 1ns/1ps
module ccg_bus_partner #(
  parameter int WAIT_CLKS = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus pins from the processor
  input wire logic [7:0] adOut,
  input wire logic ale,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic ioM,
  input wire logic dmaUpperAddrStrobe,
  // Pins back to the processor
  output logic [7:0] adIn,
  output logic readyIn
);
  logic [7:0] mem [0:15];
  logic [3:0] idx;
  logic [5:0] waitCnt;
  logic aleD;
  // Latching parts also latch on the DMA upper-address strobe, not only on ale
  wire latchStrobe = ale | dmaUpperAddrStrobe;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aleD <= 1'b0;
      idx <= 4'h0;
      waitCnt <= 6'h00;
    end else begin
      aleD <= latchStrobe;
      if (aleD && !latchStrobe) begin
        idx <= adOut[3:0];
      end
      // One bus clock of wait on I/O only; memory runs at full speed
      if (aleD && !latchStrobe && ioM) begin
        waitCnt <= 6'(WAIT_CLKS);
      end else if (waitCnt != 6'h00) begin
        waitCnt <= waitCnt - 6'h01;
      end
      if (!wrN) begin
        mem[idx] <= adOut;
      end
    end
  end
  assign readyIn = (waitCnt == 6'h00);
  // Released bus shows the inverse so a stale sample cannot pass
  assign adIn = !rdN ? mem[idx] : ~mem[idx];
endmodule : ccg_bus_partner

// file: ccg_clock_divider.sv
// Crystal input synchroniser and divide-by-two phase generator
`timescale 1ns/1ps
module ccg_clock_divider (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Crystal pin
  input wire logic crystalIn,
  // Phases and edge markers
  output logic phase1,
  output logic phase2,
  output logic busClkRise,
  output logic busClkFall
);

  // ----------------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------------
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic xtalLevel_reg;
  logic xtalRise;
  logic divide_reg;
  logic rise_reg;
  logic fall_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= crystalIn;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // A level counts only once the second and third stages agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xtalLevel_reg <= 1'b0;
    end else if (sync2_reg == sync3_reg) begin
      xtalLevel_reg <= sync3_reg;
    end
  end

  assign xtalRise = (sync2_reg == sync3_reg) && sync3_reg && !xtalLevel_reg;

  // ----------------------------------------------------------------------
  // Divide flip-flop
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divide_reg <= ccg_pkg::RST_CLK_OUT;
    end else if (xtalRise) begin
      divide_reg <= !divide_reg;
    end
  end

  // Markers are high in the cycle the divider has just changed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      rise_reg <= xtalRise && !divide_reg;
      fall_reg <= xtalRise && divide_reg;
    end
  end

  assign phase1 = divide_reg;
  assign phase2 = !divide_reg;
  assign busClkRise = rise_reg;
  assign busClkFall = fall_reg;

endmodule : ccg_clock_divider

// file: ccg_cpu_bus.sv
// Processor clock output and multiplexed bus cycle sequencer
//
// Contract
// - Each rising crystal edge toggles a divide flip-flop that drives all internal phases.
// - A bus clock period spans two crystal periods, half the input rate.
// - The clock output comes from the first divider phase, not the crystal.
// - Low and high address bytes are launched on a falling output clock edge.
// - Write data is driven starting from a falling output clock edge.
// - Read data is sampled on a rising output clock edge.
`timescale 1ns/1ps
module ccg_cpu_bus #(
  parameter int ADDR_W = ccg_pkg::ADDR_W,
  parameter int DATA_W = ccg_pkg::DATA_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Crystal and clock output
  input wire logic crystalIn,
  output logic clkOut,
  // Multiplexed low address and data pins
  input wire logic [DATA_W-1:0] adIn,
  output logic [DATA_W-1:0] adOut,
  output logic adOeN,
  // Upper address and control pins
  output logic [ADDR_W-DATA_W-1:0] addrHigh,
  output logic ale,
  output logic rdN,
  output logic wrN,
  output logic ioM,
  input wire logic readyIn,
  // User request side
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic reqWrite,
  input wire logic reqIo,
  input wire logic [DATA_W-1:0] reqWdata,
  // User answer side
  output logic rspValid,
  output logic [DATA_W-1:0] rspData
);

  // ----------------------------------------------------------------------
  // Phase generation
  // ----------------------------------------------------------------------
  logic phase1;
  logic busRise;
  logic busFall;

  ccg_clock_divider uDivider (
    .clk(clk),
    .rstn(rstn),
    .crystalIn(crystalIn),
    .phase1(phase1),
    .phase2(),
    .busClkRise(busRise),
    .busClkFall(busFall)
  );

  // Pin is phase1 itself so no crystal path reaches it directly
  assign clkOut = phase1;

  // ----------------------------------------------------------------------
  // Ready pin synchroniser
  // ----------------------------------------------------------------------
  logic rdySync1_reg;
  logic rdySync2_reg;
  logic rdySync3_reg;
  logic readyLevel_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdySync1_reg <= 1'b1;
      rdySync2_reg <= 1'b1;
      rdySync3_reg <= 1'b1;
    end else begin
      rdySync1_reg <= readyIn;
      rdySync2_reg <= rdySync1_reg;
      rdySync3_reg <= rdySync2_reg;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readyLevel_reg <= 1'b1;
    end else if (rdySync2_reg == rdySync3_reg) begin
      readyLevel_reg <= rdySync3_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Pending request
  // ----------------------------------------------------------------------
  ccg_pkg::ccg_state_t state_reg;
  logic pending_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic write_reg;
  logic io_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic take;
  logic readySeen_reg;

  // One request is held until the next falling edge starts its cycle
  assign reqReady = (state_reg == ccg_pkg::ST_IDLE) && !pending_reg;
  assign take = reqValid && reqReady;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pending_reg <= 1'b0;
    end else if (take) begin
      pending_reg <= 1'b1;
    end else if (busFall && state_reg == ccg_pkg::ST_IDLE) begin
      pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_reg <= ccg_pkg::RST_ADDR;
      write_reg <= 1'b0;
      io_reg <= 1'b0;
      wdata_reg <= ccg_pkg::RST_BYTE;
    end else if (take) begin
      addr_reg <= reqAddr;
      write_reg <= reqWrite;
      io_reg <= reqIo;
      wdata_reg <= reqWdata;
    end
  end

  // ----------------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------------
  // States change only on output clock falling edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ccg_pkg::ST_IDLE;
    end else if (busFall) begin
      case (state_reg)
        ccg_pkg::ST_IDLE: begin
          if (pending_reg) begin
            state_reg <= ccg_pkg::ST_T1;
          end
        end
        ccg_pkg::ST_T1: begin
          state_reg <= ccg_pkg::ST_T2;
        end
        ccg_pkg::ST_T2,
        ccg_pkg::ST_TW: begin
          // Ready was looked at on the rising edge inside this state
          if (readySeen_reg) begin
            state_reg <= ccg_pkg::ST_T3;
          end else begin
            state_reg <= ccg_pkg::ST_TW;
          end
        end
        ccg_pkg::ST_T3: begin
          state_reg <= ccg_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= ccg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Ready sampled on the rising edge of T2 or a wait state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readySeen_reg <= 1'b1;
    end else if (busRise && (state_reg == ccg_pkg::ST_T2 ||
                             state_reg == ccg_pkg::ST_TW)) begin
      readySeen_reg <= readyLevel_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Address, latch strobe and status
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addrHigh <= ccg_pkg::RST_BYTE;
      ioM <= 1'b0;
      ale <= ccg_pkg::RST_ALE;
    end else if (busFall && state_reg == ccg_pkg::ST_IDLE && pending_reg) begin
      addrHigh <= addr_reg[ADDR_W-1:DATA_W];
      ioM <= io_reg;
      ale <= 1'b1;
    end else if (busRise && state_reg == ccg_pkg::ST_T1) begin
      // Latch strobe trails on the rising edge of T1
      ale <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Multiplexed low byte
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      adOut <= ccg_pkg::RST_BYTE;
      adOeN <= ccg_pkg::RST_OE_N;
    end else if (busFall) begin
      case (state_reg)
        ccg_pkg::ST_IDLE: begin
          if (pending_reg) begin
            adOut <= addr_reg[DATA_W-1:0];
            adOeN <= 1'b0;
          end
        end
        ccg_pkg::ST_T1: begin
          if (write_reg) begin
            adOut <= wdata_reg;
            adOeN <= 1'b0;
          end else begin
            // Float early so the responder can drive the read byte
            adOeN <= 1'b1;
          end
        end
        ccg_pkg::ST_T3: begin
          adOeN <= 1'b1;
        end
        default: begin
          adOut <= adOut;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read and write strobes
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdN <= ccg_pkg::RST_STROBE_N;
      wrN <= ccg_pkg::RST_STROBE_N;
    end else if (busFall && state_reg == ccg_pkg::ST_T1) begin
      rdN <= write_reg;
      wrN <= !write_reg;
    end else if (busFall && state_reg == ccg_pkg::ST_T3) begin
      rdN <= 1'b1;
      wrN <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Read capture and answer
  // ----------------------------------------------------------------------
  // The bus protocol holds read data steady around this edge, so no
  // synchroniser is used; the responder must meet setup and hold.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rspData <= ccg_pkg::RST_BYTE;
    end else if (busRise && state_reg == ccg_pkg::ST_T3 && !write_reg) begin
      rspData <= adIn;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rspValid <= 1'b0;
    end else begin
      rspValid <= busRise && (state_reg == ccg_pkg::ST_T3);
    end
  end

endmodule : ccg_cpu_bus

// file: ccg_cpu_bus_sva.sv
// Port checks on the processor clock and bus-timing block
`timescale 1ns/1ps
module ccg_cpu_bus_sva #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  // Clock, reset, crystal
  input wire logic clk,
  input wire logic rstn,
  input wire logic crystalIn,
  input wire logic clkOut,
  // Bus pins
  input wire logic adOeN,
  input wire logic [ADDR_W-DATA_W-1:0] addrHigh,
  input wire logic ale,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic rspValid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Last three clock-output samples, to place bus edges after a fall or rise
  logic [2:0] hist_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hist_reg <= 3'h0;
    end else begin
      hist_reg <= {hist_reg[1:0], clkOut};
    end
  end
  wire fellNear = !clkOut && (hist_reg != 3'h0);
  wire roseNear = clkOut && (hist_reg != 3'h7);

  a_clk_follows_xtal: assert property (
    $rose(crystalIn) |-> ##[3:6] $changed(clkOut)) else $error("late toggle");
  a_clk_half_rate: assert property (
    $fell(crystalIn) |-> ##2 $stable(clkOut)[*6]) else $error("toggle on fall");
  a_addr_on_fall: assert property (
    $changed(addrHigh) |-> fellNear) else $error("upper address off fall");
  a_ale_on_fall: assert property (
    $rose(ale) |-> fellNear && !adOeN) else $error("address strobe off fall");
  a_ale_width: assert property (
    $rose(ale) |=> ale[*8]) else $error("address strobe too short");
  a_write_on_fall: assert property (
    $fell(wrN) |-> fellNear && !adOeN) else $error("write data off fall");
  a_read_float: assert property (
    $fell(rdN) |-> adOeN) else $error("bus driven during read");
  a_sample_on_rise: assert property (
    $rose(rspValid) |-> roseNear) else $error("read not on rise");

  c_read: cover property ($fell(rdN));
  c_write: cover property ($fell(wrN));
  c_answer: cover property ($rose(rspValid));
endmodule : ccg_cpu_bus_sva

bind ccg_cpu_bus ccg_cpu_bus_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
  ccg_cpu_bus_sva_i (.clk(clk), .rstn(rstn), .crystalIn(crystalIn),
  .clkOut(clkOut), .adOeN(adOeN), .addrHigh(addrHigh), .ale(ale),
  .rdN(rdN), .wrN(wrN), .rspValid(rspValid));

// file: ccg_pkg.sv
// Shared constants and types for the processor clock and bus-timing block
package ccg_pkg;

  // ----------------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int ADDR_LO_W = 8;

  // ----------------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  // Crystal periods in one output clock period
  localparam int XTAL_PER_BUS_CLK = 2;
  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic RST_CLK_OUT = 1'b0;
  localparam logic RST_STROBE_N = 1'b1;
  localparam logic RST_ALE = 1'b0;
  localparam logic RST_OE_N = 1'b1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_ADDR = 16'h0000;

  // ----------------------------------------------------------------------
  // Bus machine states
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_T1   = 5'b00010,
    ST_T2   = 5'b00100,
    ST_TW   = 5'b01000,
    ST_T3   = 5'b10000
  } ccg_state_t;

endpackage : ccg_pkg

// file: tb_top.sv
// Self-checking bench for the processor clock and bus-timing block
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic w; logic io; logic [15:0] a; logic [7:0] d;} ccg_row_t;
  logic clk, rstn, crystalIn, reqValid, reqReady, reqWrite, reqIo, rspValid;
  logic clkOut, adOeN, ale, rdN, wrN, ioM, readyIn, dmaStrobe;
  logic [15:0] reqAddr;
  logic [7:0] reqWdata, adIn, adOut, addrHigh, rspData;
  int n_mismatch = 0;
  int cmp_count = 0;
  ccg_row_t rows [6] = '{'{1, 0, 16'h12A3, 8'h5A}, '{1, 0, 16'hFF04, 8'hC3},
    '{0, 0, 16'h12A3, 8'h5A}, '{1, 1, 16'h0007, 8'h81},
    '{0, 1, 16'h0007, 8'h81}, '{0, 0, 16'hFF04, 8'hC3}};

  ccg_cpu_bus ccg_cpu_bus_i (.clk(clk), .rstn(rstn), .crystalIn(crystalIn),
    .clkOut(clkOut), .adIn(adIn), .adOut(adOut), .adOeN(adOeN),
    .addrHigh(addrHigh), .ale(ale), .rdN(rdN), .wrN(wrN), .ioM(ioM),
    .readyIn(readyIn), .reqValid(reqValid), .reqReady(reqReady),
    .reqAddr(reqAddr), .reqWrite(reqWrite), .reqIo(reqIo),
    .reqWdata(reqWdata), .rspValid(rspValid), .rspData(rspData));
  ccg_bus_partner ccg_bus_partner_i (.clk(clk), .rstn(rstn), .adOut(adOut),
    .ale(ale), .rdN(rdN), .wrN(wrN), .ioM(ioM),
    .dmaUpperAddrStrobe(dmaStrobe), .adIn(adIn), .readyIn(readyIn));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // Issue one request and wait, bounded, for its address strobe
  task automatic take(input ccg_row_t r);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    reqValid = 1'b1;
    reqWrite = r.w;
    reqIo = r.io;
    reqAddr = r.a;
    reqWdata = r.d;
    @(negedge clk);
    reqValid = 1'b0;
    n = 0;
    while (ale !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check(16'(ale), 16'h0001);
  endtask : take

  task automatic do_op(input ccg_row_t r);
    int n;
    int rises;
    logic prev, seenW;
    take(r);
    check(16'(addrHigh), 16'(r.a[15:8]));
    check(16'(adOut), 16'(r.a[7:0]));
    check(16'(ioM), 16'(r.io));
    rises = 0;
    seenW = 1'b0;
    prev = clkOut;
    n = 0;
    while (rspValid !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
      if (clkOut && !prev) rises++;
      prev = clkOut;
      if (!wrN && !seenW) begin
        check(16'(adOut), 16'(r.d));
        seenW = 1'b1;
      end
    end
    check(16'(rspValid), 16'h0001);
    check(16'(seenW), 16'(r.w));
    check(16'(rises), r.io ? 16'h0004 : 16'h0003);
    if (!r.w) check(16'(rspData), 16'(r.d));
  endtask : do_op

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Crystal at one twelfth of the clock: a bus clock is 24 clocks
  initial begin
    crystalIn = 1'b0;
    forever begin
      repeat (6) @(negedge clk);
      crystalIn = ~crystalIn;
    end
  end

  initial begin
    #(40 * 20000);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    rstn = 1'b0;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqIo = 1'b0;
    reqAddr = 16'h0000;
    reqWdata = 8'h00;
    dmaStrobe = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    foreach (rows[i]) begin
      do_op(rows[i]);
      $display("row %0d done", i);
    end
    // Reset before the write strobe: the stored byte must survive
    take('{1, 0, 16'h12A3, 8'hEE});
    @(negedge crystalIn);
    @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    check(16'({clkOut, adOeN, ale, rdN, wrN, reqReady, rspValid}), 16'h002E);
    check(16'(addrHigh), 16'h0000);
    @(negedge clk);
    rstn = 1'b1;
    do_op(rows[2]);
    $display("mid-cycle reset done");
    end_of_test();
  end
endmodule : tb_top
